// *** logic/pac_checker.sv ***
// What this block does
// - Each region classed main memory or I/O
// - Main memory gets relaxed model only
// - Relaxed I/O needs no extra ordering
// - Strong I/O observed in program order
// - Strong I/O region carries ordering channel
// - Channel 0 orders single region only
// - Channel 1 fences I/O before and after
// - Higher channels order within same channel
// - Main memory idempotent; I/O read/write flags
// - No speculative access to non-idempotent data
// - Ordering changes are not side effects
// - Coherent regions name their coherence controller
// - Protection checked beside attribute check
// - Machine-only writable permission state per region
// - Fixed region grants machine mode only
// - Protection applies to lower modes always
// - Machine loads/stores checked under modify-privilege
// - Violation traps precisely, access suppressed
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "pac_defs.svh"
module pac_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_m_mode,
  output logic [31:0] reg_rdata,
  input wire logic chk_valid,
  input wire logic [31:0] chk_addr,
  input wire pac_pkg::pac_acc_t chk_type,
  input wire pac_pkg::pac_priv_t chk_priv,
  input wire logic modify_privilege_bit,
  input wire pac_pkg::pac_priv_t previous_privilege_field,
  input wire logic chk_speculative,
  output logic rsp_valid,
  output logic rsp_fault,
  output logic rsp_attr_fault,
  output logic rsp_prot_fault,
  output logic rsp_defer,
  output logic rsp_is_io,
  output pac_pkg::pac_ord_t rsp_order,
  output logic [3:0] rsp_channel,
  output logic rsp_fence_before,
  output logic rsp_fence_after,
  output logic rsp_idempotent,
  output logic rsp_coherent,
  output logic [2:0] rsp_coh_id
);
  import pac_pkg::*;

  localparam int NR = `PAC_NREG;

  logic [31:0] base_q [NR];
  logic [31:0] base_d [NR];
  logic [31:0] limit_q [NR];
  logic [31:0] limit_d [NR];
  logic [`PAC_A_W-1:0] attr_q [NR];
  logic [`PAC_A_W-1:0] attr_d [NR];
  logic [`PAC_P_WIDTH-1:0] perm_q [NR];
  logic [`PAC_P_WIDTH-1:0] perm_d [NR];
  logic [31:0] faddr_q, faddr_d;
  logic [3:0] fcause_q, fcause_d;
  logic [15:0] fcount_q, fcount_d;
  logic [31:0] rdata_q, rdata_d;

  logic hit;
  logic [1:0] hit_idx;
  logic [`PAC_A_W-1:0] a;
  logic prot_on;
  pac_priv_t eff_priv;
  logic allow;
  logic attr_bad;
  logic prot_bad;
  logic nonidem;

  logic v_q, v_d;
  logic fault_q, fault_d;
  logic af_q, af_d;
  logic pf_q, pf_d;
  logic defer_q, defer_d;
  logic io_q, io_d;
  pac_ord_t ord_q, ord_d;
  logic [3:0] ch_q, ch_d;
  logic fb_q, fb_d;
  logic fa_q, fa_d;
  logic idem_q, idem_d;
  logic coh_q, coh_d;
  logic [2:0] cid_q, cid_d;

  function automatic logic in_range(input logic [31:0] ad, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (ad >= lo) && (ad <= hi);
  endfunction : in_range

  function automatic logic [1:0] reg_index(input logic [7:0] ad);
    reg_index = ad[5:4];
  endfunction : reg_index

  function automatic logic is_region(input logic [7:0] ad);
    is_region = (ad < (`PAC_OFS_STRIDE * 8'(NR))) && (ad[1:0] == 2'h0);
  endfunction : is_region

  // Region lookup; lowest enabled matching region wins.
  always_comb begin
    hit = 1'b0;
    hit_idx = 2'h0;
    for (int i = NR - 1; i >= 0; i--) begin
      if (attr_q[i][`PAC_A_EN] && in_range(chk_addr, base_q[i], limit_q[i])) begin
        hit = 1'b1;
        hit_idx = 2'(i);
      end
    end
  end

  // A miss is an empty I/O region that supports no access.
  assign a = hit ? attr_q[hit_idx] : `PAC_A_W'(1);

  // Effective privilege and whether protection applies.
  always_comb begin
    eff_priv = chk_priv;
    prot_on = 1'b1;
    if (chk_priv == PAC_PRIV_M) begin
      prot_on = 1'b0;
      if ((chk_type != PAC_FETCH) && modify_privilege_bit
          && (previous_privilege_field != PAC_PRIV_M)) begin
        prot_on = 1'b1;
        eff_priv = previous_privilege_field;
      end
    end
  end

  // Protection check, evaluated in the same cycle as the attribute check.
  always_comb begin
    allow = 1'b0;
    if (hit) begin
      unique case (chk_type)
        PAC_FETCH: allow = perm_q[hit_idx][`PAC_P_X];
        PAC_LOAD: allow = perm_q[hit_idx][`PAC_P_R];
        PAC_STORE: allow = perm_q[hit_idx][`PAC_P_W];
        default: allow = 1'b0;
      endcase
      if (hit_idx == 2'(`PAC_FIXED_REGION)) begin
        allow = (eff_priv == PAC_PRIV_M);
      end
    end
  end

  assign prot_bad = prot_on && !allow;
  assign attr_bad = !hit || (chk_type == PAC_FETCH && a[`PAC_A_IO]);

  // Main memory is idempotent; I/O uses the per-direction flag.
  always_comb begin
    nonidem = 1'b0;
    if (a[`PAC_A_IO]) begin
      if (chk_type == PAC_STORE) begin
        nonidem = !a[`PAC_A_WR_IDEM];
      end else begin
        nonidem = !a[`PAC_A_RD_IDEM];
      end
    end
  end

  // Response next state.
  always_comb begin
    v_d = chk_valid;
    af_d = chk_valid && attr_bad;
    pf_d = chk_valid && prot_bad;
    fault_d = chk_valid && (attr_bad || prot_bad);
    defer_d = chk_valid && !fault_d && chk_speculative && nonidem;
    io_d = a[`PAC_A_IO];
    idem_d = !nonidem;
    coh_d = a[`PAC_A_COH];
    cid_d = a[`PAC_A_COH] ? a[`PAC_A_COHID_HI:`PAC_A_COHID_LO] : 3'h0;
    ch_d = 4'h0;
    fb_d = 1'b0;
    fa_d = 1'b0;
    ord_d = PAC_ORD_NONE;
    if (a[`PAC_A_IO] && a[`PAC_A_STRONG]) begin
      ch_d = a[`PAC_A_CHAN_HI:`PAC_A_CHAN_LO];
      if (ch_d == 4'h0) begin
        ord_d = PAC_ORD_POINT;
      end else if (ch_d == 4'h1) begin
        ord_d = PAC_ORD_GLOBAL;
        fb_d = 1'b1;
        fa_d = 1'b1;
      end else begin
        ord_d = PAC_ORD_CHANNEL;
      end
    end else if (a[`PAC_A_IO]) begin
      ord_d = PAC_ORD_NONE;
    end
    if (!chk_valid) begin
      ord_d = PAC_ORD_NONE;
      fb_d = 1'b0;
      fa_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      v_q <= 1'b0;
      fault_q <= 1'b0;
      af_q <= 1'b0;
      pf_q <= 1'b0;
      defer_q <= 1'b0;
      io_q <= 1'b0;
      ord_q <= PAC_ORD_NONE;
      ch_q <= 4'h0;
      fb_q <= 1'b0;
      fa_q <= 1'b0;
      idem_q <= 1'b1;
      coh_q <= 1'b0;
      cid_q <= 3'h0;
    end else begin
      v_q <= v_d;
      fault_q <= fault_d;
      af_q <= af_d;
      pf_q <= pf_d;
      defer_q <= defer_d;
      io_q <= io_d;
      ord_q <= ord_d;
      ch_q <= ch_d;
      fb_q <= fb_d;
      fa_q <= fa_d;
      idem_q <= idem_d;
      coh_q <= coh_d;
      cid_q <= cid_d;
    end
  end

  // The fault is returned with the result so the pipeline traps precisely.
  assign rsp_valid = v_q;
  assign rsp_fault = fault_q;
  assign rsp_attr_fault = af_q;
  assign rsp_prot_fault = pf_q;
  assign rsp_defer = defer_q;
  assign rsp_is_io = io_q;
  assign rsp_order = ord_q;
  assign rsp_channel = ch_q;
  assign rsp_fence_before = fb_q;
  assign rsp_fence_after = fa_q;
  assign rsp_idempotent = idem_q;
  assign rsp_coherent = coh_q;
  assign rsp_coh_id = cid_q;

  // Region table writes, accepted only from machine mode.
  always_comb begin
    for (int i = 0; i < NR; i++) begin
      base_d[i] = base_q[i];
      limit_d[i] = limit_q[i];
      attr_d[i] = attr_q[i];
      perm_d[i] = perm_q[i];
    end
    if (reg_wr && reg_m_mode && is_region(reg_addr)) begin
      unique case (reg_addr[3:0])
        `PAC_OFS_BASE: base_d[reg_index(reg_addr)] = reg_wdata;
        `PAC_OFS_LIMIT: limit_d[reg_index(reg_addr)] = reg_wdata;
        `PAC_OFS_ATTR: attr_d[reg_index(reg_addr)] = reg_wdata[`PAC_A_W-1:0];
        `PAC_OFS_PERM: perm_d[reg_index(reg_addr)] = reg_wdata[`PAC_P_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < NR; i++) begin
        base_q[i] <= `PAC_RST_BASE;
        limit_q[i] <= (i == NR - 1) ? `PAC_RST_LIMIT_LAST : `PAC_RST_LIMIT;
        attr_q[i] <= (i == NR - 1) ? `PAC_RST_ATTR_LAST : `PAC_RST_ATTR;
        perm_q[i] <= (i == NR - 1) ? `PAC_RST_PERM_LAST : `PAC_RST_PERM;
      end
    end else begin
      for (int i = 0; i < NR; i++) begin
        base_q[i] <= base_d[i];
        limit_q[i] <= limit_d[i];
        attr_q[i] <= attr_d[i];
        perm_q[i] <= perm_d[i];
      end
    end
  end

  // Fault record: last faulting address, cause and a saturating count.
  always_comb begin
    faddr_d = faddr_q;
    fcause_d = fcause_q;
    fcount_d = fcount_q;
    if (reg_wr && reg_m_mode && reg_addr == `PAC_OFS_FCOUNT) begin
      fcount_d = 16'h0000;
    end
    if (fault_d) begin
      faddr_d = chk_addr;
      fcause_d = {pf_d, af_d, chk_type};
      if (fcount_d != 16'hFFFF) begin
        fcount_d = fcount_d + 16'h0001;
      end
    end
  end

  // Read data stands in the cycle after the read strobe.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (is_region(reg_addr)) begin
        unique case (reg_addr[3:0])
          `PAC_OFS_BASE: rdata_d = base_q[reg_index(reg_addr)];
          `PAC_OFS_LIMIT: rdata_d = limit_q[reg_index(reg_addr)];
          `PAC_OFS_ATTR: rdata_d = 32'(attr_q[reg_index(reg_addr)]);
          `PAC_OFS_PERM: rdata_d = 32'(perm_q[reg_index(reg_addr)]);
          default: rdata_d = 32'h0000_0000;
        endcase
      end else if (reg_addr == `PAC_OFS_FADDR) begin
        rdata_d = faddr_q;
      end else if (reg_addr == `PAC_OFS_FCAUSE) begin
        rdata_d = 32'(fcause_q);
      end else if (reg_addr == `PAC_OFS_FCOUNT) begin
        rdata_d = 32'(fcount_q);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      faddr_q <= 32'h0000_0000;
      fcause_q <= 4'h0;
      fcount_q <= 16'h0000;
      rdata_q <= 32'h0000_0000;
    end else begin
      faddr_q <= faddr_d;
      fcause_q <= fcause_d;
      fcount_q <= fcount_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : pac_checker

// *** logic/pac_defs.svh ***
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH

`define PAC_NREG 4
`define PAC_AW 8
`define PAC_OFS_STRIDE 8'h10
`define PAC_OFS_BASE 8'h00
`define PAC_OFS_LIMIT 8'h04
`define PAC_OFS_ATTR 8'h08
`define PAC_OFS_PERM 8'h0C
`define PAC_OFS_FADDR 8'h40
`define PAC_OFS_FCAUSE 8'h44
`define PAC_OFS_FCOUNT 8'h48

`define PAC_A_IO 0
`define PAC_A_STRONG 1
`define PAC_A_CHAN_LO 2
`define PAC_A_CHAN_HI 5
`define PAC_A_RD_IDEM 6
`define PAC_A_WR_IDEM 7
`define PAC_A_COH 8
`define PAC_A_COHID_LO 9
`define PAC_A_COHID_HI 11
`define PAC_A_EN 12
`define PAC_A_W 13

`define PAC_P_R 0
`define PAC_P_W 1
`define PAC_P_X 2
`define PAC_P_WIDTH 3

`define PAC_FIXED_REGION 0
`define PAC_RST_BASE 32'h0000_0000
`define PAC_RST_LIMIT 32'h0000_0000
`define PAC_RST_ATTR 13'h0000
`define PAC_RST_PERM 3'h0
`define PAC_RST_LIMIT_LAST 32'hFFFF_FFFF
`define PAC_RST_ATTR_LAST 13'h10C0
`define PAC_RST_PERM_LAST 3'h7

`endif

// *** logic/pac_pkg.sv ***
package pac_pkg;
  typedef enum logic [1:0] {
    PAC_FETCH = 2'h0,
    PAC_LOAD = 2'h1,
    PAC_STORE = 2'h2
  } pac_acc_t;
  typedef enum logic [1:0] {
    PAC_PRIV_U = 2'h0,
    PAC_PRIV_S = 2'h1,
    PAC_PRIV_H = 2'h2,
    PAC_PRIV_M = 2'h3
  } pac_priv_t;
  typedef enum logic [1:0] {
    PAC_ORD_NONE = 2'h0,
    PAC_ORD_POINT = 2'h1,
    PAC_ORD_GLOBAL = 2'h2,
    PAC_ORD_CHANNEL = 2'h3
  } pac_ord_t;
endpackage : pac_pkg

// *** tb/pac_checker_chk.sv ***
`timescale 1ns/10ps
module pac_checker_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic chk_valid,
  input wire pac_pkg::pac_acc_t chk_type,
  input wire pac_pkg::pac_priv_t chk_priv,
  input wire logic modify_privilege_bit,
  input wire logic chk_speculative,
  input wire logic rsp_valid,
  input wire logic rsp_fault,
  input wire logic rsp_attr_fault,
  input wire logic rsp_prot_fault,
  input wire logic rsp_defer,
  input wire logic rsp_is_io,
  input wire pac_pkg::pac_ord_t rsp_order,
  input wire logic [3:0] rsp_channel,
  input wire logic rsp_fence_before,
  input wire logic rsp_fence_after,
  input wire logic rsp_idempotent
);
  import pac_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_m_bypass;
    chk_valid && chk_priv == PAC_PRIV_M && (chk_type == PAC_FETCH || !modify_privilege_bit);
  endsequence
  sequence s_clean;
    rsp_valid && !rsp_fault;
  endsequence
  property p_lat; chk_valid |=> rsp_valid; endproperty
  property p_idle; !chk_valid |=> !rsp_valid; endproperty
  property p_fault; rsp_valid |-> rsp_fault == (rsp_attr_fault || rsp_prot_fault); endproperty
  property p_bypass; s_m_bypass |=> !rsp_prot_fault; endproperty
  property p_ch1;
    rsp_valid && rsp_order == PAC_ORD_GLOBAL |->
      rsp_fence_before && rsp_fence_after && rsp_channel == 4'h1;
  endproperty
  property p_ch0;
    rsp_valid && rsp_order == PAC_ORD_POINT |-> rsp_channel == 4'h0 && !rsp_fence_after;
  endproperty
  property p_chan; rsp_valid && rsp_order == PAC_ORD_CHANNEL |-> rsp_channel > 4'h1; endproperty
  property p_main;
    rsp_valid && !rsp_is_io |-> rsp_order == PAC_ORD_NONE && rsp_idempotent;
  endproperty
  property p_defer; rsp_defer |-> s_clean ##0 !rsp_idempotent; endproperty
  property p_spec; chk_valid && !chk_speculative |=> !rsp_defer; endproperty
  a_lat: assert property (p_lat) else $error("no response after check");
  a_idle: assert property (p_idle) else $error("response without check");
  a_fault: assert property (p_fault) else $error("fault not sum of causes");
  a_bypass: assert property (p_bypass) else $error("machine access denied");
  a_ch1: assert property (p_ch1) else $error("global order without fences");
  a_ch0: assert property (p_ch0) else $error("point order on wrong channel");
  a_chan: assert property (p_chan) else $error("channel order on low channel");
  a_main: assert property (p_main) else $error("main memory not relaxed");
  a_defer: assert property (p_defer) else $error("bad defer");
  a_spec: assert property (p_spec) else $error("defer without speculation");
endmodule : pac_checker_chk

bind pac_checker pac_checker_chk i_pac_checker_chk (.*);

// *** tb/pac_hart.sv ***
`timescale 1ns/10ps
module pac_hart (
  input wire logic clk_sys,
  output logic chk_valid,
  output logic [31:0] chk_addr,
  output pac_pkg::pac_acc_t chk_type,
  output pac_pkg::pac_priv_t chk_priv,
  output logic modify_privilege_bit,
  output pac_pkg::pac_priv_t previous_privilege_field,
  output logic chk_speculative
);
  import pac_pkg::*;
  initial begin
    chk_valid = 1'b0;
    chk_addr = 32'h0000_0000;
    chk_type = PAC_FETCH;
    chk_priv = PAC_PRIV_M;
    modify_privilege_bit = 1'b0;
    previous_privilege_field = PAC_PRIV_U;
    chk_speculative = 1'b0;
  end
  // Presents one access for one cycle, then scrambles the released address.
  task automatic issue(input logic [31:0] a, input pac_acc_t t, input pac_priv_t p,
                       input logic m, input pac_priv_t pp, input logic s);
    @(posedge clk_sys);
    chk_valid <= 1'b1;
    chk_addr <= a;
    chk_type <= t;
    chk_priv <= p;
    modify_privilege_bit <= m;
    previous_privilege_field <= pp;
    chk_speculative <= s;
    @(posedge clk_sys);
    chk_valid <= 1'b0;
    chk_addr <= ~a;
    #1;
  endtask : issue
endmodule : pac_hart

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import pac_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_m_mode = 1'b1;
  logic [31:0] reg_rdata, chk_addr;
  logic chk_valid, modify_privilege_bit, chk_speculative;
  pac_acc_t chk_type;
  pac_priv_t chk_priv, previous_privilege_field;
  logic rsp_valid, rsp_fault, rsp_attr_fault, rsp_prot_fault, rsp_defer, rsp_is_io;
  logic rsp_fence_before, rsp_fence_after, rsp_idempotent, rsp_coherent;
  pac_ord_t rsp_order;
  logic [3:0] rsp_channel;
  logic [2:0] rsp_coh_id;
  int fail_count = 0;
  int n_tests = 0;
  always #2.5 clk_sys = ~clk_sys;
  pac_checker i_pac_checker (.*);
  pac_hart i_pac_hart (.*);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic m);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_m_mode <= m;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_m_mode <= 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask : rd
  // Expected nibbles: valid, {fault,attr,prot,defer}, io, order, channel, fences, idem, coh.
  task automatic run(input logic [31:0] a, input pac_acc_t t, input pac_priv_t p,
                     input logic m, input pac_priv_t pp, input logic s, input logic [31:0] exp);
    i_pac_hart.issue(a, t, p, m, pp, s);
    chk("rsp", {3'b0, rsp_valid, rsp_fault, rsp_attr_fault, rsp_prot_fault, rsp_defer,
                3'b0, rsp_is_io, 2'b0, rsp_order, rsp_channel, 2'b0, rsp_fence_before,
                rsp_fence_after, 3'b0, rsp_idempotent, rsp_coherent, rsp_coh_id}, exp);
  endtask : run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h34, 32'hFFFF_FFFF);
    rd(8'h38, 32'h0000_10C0);
    rd(8'h3C, 32'h0000_0007);
    rd(8'h08, 32'h0000_0000);
    rd(8'h80, 32'h0000_0000);
    $display("test reset map done");
    wr(8'h04, 32'h0000_00FF, 1'b1);
    wr(8'h08, 32'h0000_1000, 1'b1);
    wr(8'h0C, 32'h0000_0007, 1'b1);
    wr(8'h10, 32'h0000_1000, 1'b1);
    wr(8'h14, 32'h0000_1FFF, 1'b1);
    wr(8'h18, 32'h0000_1007, 1'b1);
    wr(8'h1C, 32'h0000_0003, 1'b1);
    wr(8'h20, 32'h0000_2000, 1'b1);
    wr(8'h24, 32'h0000_2FFF, 1'b1);
    wr(8'h28, 32'h0000_1B4F, 1'b1);
    wr(8'h2C, 32'h0000_0001, 1'b1);
    wr(8'h2C, 32'h0000_0007, 1'b0);
    rd(8'h2C, 32'h0000_0001);
    rd(8'h28, 32'h0000_1B4F);
    run(32'h80, PAC_LOAD, PAC_PRIV_U, 1'b0, PAC_PRIV_U, 1'b0, 32'h1A00_0010);
    run(32'h80, PAC_LOAD, PAC_PRIV_M, 1'b0, PAC_PRIV_U, 1'b0, 32'h1000_0010);
    run(32'h80, PAC_LOAD, PAC_PRIV_M, 1'b1, PAC_PRIV_U, 1'b0, 32'h1A00_0010);
    run(32'h80, PAC_LOAD, PAC_PRIV_M, 1'b1, PAC_PRIV_M, 1'b0, 32'h1000_0010);
    run(32'h1000, PAC_STORE, PAC_PRIV_S, 1'b0, PAC_PRIV_U, 1'b0, 32'h1012_1300);
    run(32'h2000, PAC_LOAD, PAC_PRIV_U, 1'b0, PAC_PRIV_U, 1'b1, 32'h1013_301D);
    run(32'h2000, PAC_STORE, PAC_PRIV_U, 1'b0, PAC_PRIV_U, 1'b1, 32'h1A13_300D);
    run(32'h2000, PAC_STORE, PAC_PRIV_M, 1'b0, PAC_PRIV_U, 1'b1, 32'h1113_300D);
    run(32'h5000, PAC_STORE, PAC_PRIV_U, 1'b0, PAC_PRIV_U, 1'b1, 32'h1000_0010);
    wr(8'h18, 32'h0000_1003, 1'b1);
    run(32'h1000, PAC_LOAD, PAC_PRIV_U, 1'b0, PAC_PRIV_U, 1'b0, 32'h1011_0000);
    wr(8'h18, 32'h0000_1041, 1'b1);
    run(32'h1000, PAC_LOAD, PAC_PRIV_U, 1'b0, PAC_PRIV_U, 1'b1, 32'h1010_0010);
    $display("test access checks done");
    rd(8'h40, 32'h0000_2000);
    rd(8'h44, 32'h0000_000A);
    rd(8'h48, 32'h0000_0003);
    wr(8'h48, 32'h0000_0000, 1'b1);
    rd(8'h48, 32'h0000_0000);
    $display("test fault log done");
    print_verdict();
  end
endmodule : testbench
